// file: design/insn_exec_params.svh
// offsets, vectors, opcodes, reset values and mode codes of the instruction execution unit
`ifndef INSN_EXEC_PARAMS_SVH
`define INSN_EXEC_PARAMS_SVH

// ****************************************************************
// register word indices (byte offset = 4 * index)
// ****************************************************************
`define IDX_INSN      6'h00
`define IDX_EA        6'h01
`define IDX_PSW       6'h02
`define IDX_MEMMGMT_CONTROL_THREE      6'h03
`define IDX_STATUS    6'h04
`define IDX_MEM_ADDR  6'h05
`define IDX_MEM_DATA  6'h06
`define IDX_PC        6'h07
`define IDX_GR_BASE   6'h08
`define IDX_GR_LAST   6'h0D
`define IDX_SP_BASE   6'h0E
`define IDX_SP_LAST   6'h11

// ****************************************************************
// trap vectors
// ****************************************************************
`define VEC_ILLEGAL   16'h0004
`define VEC_RESERVED  16'h0008
`define VEC_IO_TRAP   16'h0010
`define VEC_EMULATOR  16'h0018

// ****************************************************************
// opcode patterns on insn[15:6], insn[14:6], insn[15:9], insn[15:8] and the whole insn
// ****************************************************************
`define OP_CALL_SUP   10'h038
`define OP_DEC        10'h02B
`define OP_DECREMENT_BYTE_OP       10'h22B
`define OP_INC        10'h02A
`define OP_INCREMENT_BYTE_OP       10'h22A
`define OP_JUMP       10'h001
`define OP_MARK       10'h034
`define OP_MFP_DATA   10'h035
`define OP_MFP_INSN   10'h235
`define OP_MF_STATUS  10'h237
`define OP7_DIVIDE    7'h39
`define OP7_CALL      7'h04
`define OP8_EMULATOR  8'h88
`define OP_HALT       16'h0000
`define OP_IO_TRAP    16'h0004
`define OP_MODEL      16'h0007

// ****************************************************************
// status word fields and reset values
// ****************************************************************
`define PSW_CUR_HI    15
`define PSW_CUR_LO    14
`define PSW_PRV_HI    13
`define PSW_PRV_LO    12
`define PSW_TRACE     4
`define MEMMGMT_CONTROL_THREE_CSM_EN   3
`define MODE_KERNEL   2'b00
`define MODE_SUPER    2'b01
`define MODE_USER     2'b11
`define RST_PSW       16'h0000
`define RST_WORD      16'h0000

`endif

// file: design/insn_exec_pkg.sv
// types of the instruction execution unit
package insn_exec_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_EXEC = 3'b001,
    ST_PUSH = 3'b010,
    ST_VEC  = 3'b011
  } exec_state_t;

  typedef struct packed {
    exec_state_t      st;
    logic [15:0]      insn;
    logic [15:0]      ea;
    logic [15:0]      pc;
    logic [15:0]      processor_status_word;
    logic [15:0]      memmgmt_control_three;
    logic [5:0][15:0] gr;
    logic [3:0][15:0] spb;
    logic [1:0]       push_cnt;
    logic [2:0][15:0] push_w;
    logic [15:0]      vec;
    logic             vec_psw;
    logic             halted;
    logic [15:0]      last_trap;
    logic             insn_space;
    logic [15:0]      maddr;
    logic             ack;
    logic             err;
    logic [31:0]      rdata;
  } cpu_state_t;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [15:0] data;
    logic [1:0]  be;
  } mem_wr_t;

endpackage

// file: design/insn_exec_unit.sv
// execution unit for traps, calls, inc/dec, divide and status moves, with apb access
`timescale 1ns/1ps
`include "insn_exec_params.svh"

module insn_exec_unit
  import insn_exec_pkg::*;
#(
  parameter int          MEM_AW     = 9,
  parameter bit          MM_PRESENT = 1'b1,
  parameter bit          MODEL_IMPL = 1'b1,
  parameter logic [7:0]  MODEL_CODE = 8'h01, // arbitrary value
  parameter logic [7:0]  MODEL_SUB  = 8'h00  // arbitrary value
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // status
  output logic             busy,
  output logic             halted
);

  // ****************************************************************
  // state and memory
  // ****************************************************************
  cpu_state_t  s_reg;
  cpu_state_t  s_next;
  mem_wr_t     mw;
  logic [15:0] mem [0:(1<<(MEM_AW-1))-1];

  logic [15:0] m_ea;
  logic [15:0] m_vec;
  logic [15:0] m_vec2;
  logic [15:0] m_mark;
  logic [15:0] m_apb;
  logic [15:0] mark_sp;

  assign mark_sp = s_reg.pc + {9'h000, s_reg.insn[5:0], 1'b0};
  assign m_ea    = mem[s_reg.ea[MEM_AW-1:1]];
  assign m_vec   = mem[s_reg.vec[MEM_AW-1:1]];
  assign m_vec2  = mem[s_reg.vec[MEM_AW-1:1] + 1'b1];
  assign m_mark  = mem[mark_sp[MEM_AW-1:1]];
  assign m_apb   = mem[s_reg.maddr[MEM_AW-1:1]];

  assign pready  = s_reg.ack;
  assign pslverr = s_reg.ack & s_reg.err;
  assign prdata  = s_reg.rdata;
  assign busy    = (s_reg.st != ST_IDLE);
  assign halted  = s_reg.halted;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [15:0] rd_reg(input cpu_state_t s, input logic [2:0] i);
    logic [15:0] v;
    v = s.pc;
    if (i < 3'd6) begin
      v = s.gr[i];
    end else if (i == 3'd6) begin
      v = s.spb[s.processor_status_word[`PSW_CUR_HI:`PSW_CUR_LO]];
    end
    return v;
  endfunction

  function automatic cpu_state_t wr_reg(input cpu_state_t s, input logic [2:0] i, input logic [15:0] v);
    cpu_state_t t;
    t = s;
    if (i < 3'd6) begin
      t.gr[i] = v;
    end else if (i == 3'd6) begin
      t.spb[s.processor_status_word[`PSW_CUR_HI:`PSW_CUR_LO]] = v;
    end else begin
      t.pc = v;
    end
    return t;
  endfunction

  // trap entry: kernel mode, old mode to previous, push status then pc
  function automatic cpu_state_t trap(input cpu_state_t s, input logic [15:0] v);
    cpu_state_t t;
    t = s;
    t.push_w[0] = s.processor_status_word;
    t.push_w[1] = s.pc;
    t.push_cnt  = 2'd2;
    t.processor_status_word[`PSW_PRV_HI:`PSW_PRV_LO] = s.processor_status_word[`PSW_CUR_HI:`PSW_CUR_LO];
    t.processor_status_word[`PSW_CUR_HI:`PSW_CUR_LO] = `MODE_KERNEL;
    t.vec       = v;
    t.vec_psw   = 1'b1;
    t.last_trap = v;
    t.st        = ST_PUSH;
    return t;
  endfunction

  // ****************************************************************
  // apb read mux
  // ****************************************************************
  logic        hit;
  logic [31:0] rd;
  logic [5:0]  widx;

  assign widx = paddr[7:2];

  always_comb begin
    hit = (paddr[1:0] == 2'b00);
    rd  = 32'h0000_0000;
    if (widx >= `IDX_GR_BASE && widx <= `IDX_GR_LAST) begin
      rd = {16'h0000, s_reg.gr[3'(widx - `IDX_GR_BASE)]};
    end else if (widx >= `IDX_SP_BASE && widx <= `IDX_SP_LAST) begin
      rd = {16'h0000, s_reg.spb[2'(widx - `IDX_SP_BASE)]};
    end else begin
      case (widx)
        `IDX_INSN:     rd = {16'h0000, s_reg.insn};
        `IDX_EA:       rd = {16'h0000, s_reg.ea};
        `IDX_PSW:      rd = {16'h0000, s_reg.processor_status_word};
        `IDX_MEMMGMT_CONTROL_THREE:     rd = {16'h0000, s_reg.memmgmt_control_three};
        `IDX_STATUS:   rd = {s_reg.last_trap, 13'h0000, s_reg.insn_space, s_reg.halted, busy};
        `IDX_MEM_ADDR: rd = {16'h0000, s_reg.maddr};
        `IDX_MEM_DATA: rd = {16'h0000, m_apb};
        `IDX_PC:       rd = {16'h0000, s_reg.pc};
        default:       hit = 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  logic [15:0]        opw;
  logic [7:0]         opb;
  logic [15:0]        res;
  logic               mode0;
  logic               is_byte;
  logic [1:0]         cur;
  logic [1:0]         prv;
  logic [2:0]         rr;
  logic signed [31:0] dvd;
  logic signed [31:0] dvs;
  logic signed [31:0] quo;
  logic signed [31:0] rem;
  logic               apb_wr;
  logic [15:0]        wd;

  always_comb begin
    s_next  = s_reg;
    mw      = '0;
    mode0   = (s_reg.insn[5:3] == 3'b000);
    is_byte = s_reg.insn[15];
    cur     = s_reg.processor_status_word[`PSW_CUR_HI:`PSW_CUR_LO];
    prv     = s_reg.processor_status_word[`PSW_PRV_HI:`PSW_PRV_LO];
    rr      = s_reg.insn[8:6];
    opw     = mode0 ? rd_reg(s_reg, s_reg.insn[2:0]) : m_ea;
    opb     = (mode0 || !s_reg.ea[0]) ? opw[7:0] : opw[15:8];
    res     = 16'h0000;
    dvd     = $signed({rd_reg(s_reg, rr), rd_reg(s_reg, rr | 3'd1)});
    dvs     = $signed({{16{opw[15]}}, opw});
    quo     = 32'sd0;
    rem     = 32'sd0;
    apb_wr  = psel & penable & pwrite & s_reg.ack;
    wd      = pwdata[15:0];

    // apb: one wait state, answer registered
    s_next.ack = psel & penable & ~s_reg.ack;
    if (s_next.ack) begin
      s_next.err   = ~hit;
      s_next.rdata = rd;
    end
    if (apb_wr && hit && s_reg.st == ST_IDLE) begin
      if (widx >= `IDX_GR_BASE && widx <= `IDX_GR_LAST) begin
        s_next.gr[3'(widx - `IDX_GR_BASE)] = wd;
      end else if (widx >= `IDX_SP_BASE && widx <= `IDX_SP_LAST) begin
        s_next.spb[2'(widx - `IDX_SP_BASE)] = wd;
      end else begin
        case (widx)
          `IDX_INSN: begin
            s_next.insn   = wd;
            s_next.halted = 1'b0;
            s_next.st     = ST_EXEC;
          end
          `IDX_EA:       s_next.ea    = wd;
          `IDX_PSW:      s_next.processor_status_word   = wd;
          `IDX_MEMMGMT_CONTROL_THREE:     s_next.memmgmt_control_three  = wd;
          `IDX_MEM_ADDR: s_next.maddr = wd;
          `IDX_MEM_DATA: mw = '{we: 1'b1, addr: s_reg.maddr, data: wd, be: 2'b11};
          `IDX_PC:       s_next.pc    = wd;
          default:       s_next.err   = s_reg.err;
        endcase
      end
    end

    case (s_reg.st)
      ST_IDLE: begin
        s_next.push_cnt = 2'd0;
      end
      ST_EXEC: begin
        s_next.st      = ST_IDLE;
        s_next.vec_psw = 1'b0;
        if (s_reg.pc[0]) begin
          s_next = trap(s_reg, `VEC_ILLEGAL);
        end else if (s_reg.insn[15:6] == `OP_CALL_SUP) begin
          if (s_reg.memmgmt_control_three[`MEMMGMT_CONTROL_THREE_CSM_EN] && cur != `MODE_KERNEL) begin
            s_next.spb[`MODE_SUPER] = s_reg.spb[cur];
            s_next.processor_status_word[`PSW_PRV_HI:`PSW_PRV_LO] = cur;
            s_next.processor_status_word[`PSW_CUR_HI:`PSW_CUR_LO] = `MODE_SUPER;
            s_next.processor_status_word[`PSW_TRACE] = 1'b0;
            s_next.push_w[0] = {s_reg.processor_status_word[15:4], 4'h0};
            s_next.push_w[1] = s_reg.pc;
            s_next.push_w[2] = opw;
            s_next.push_cnt  = 2'd3;
            s_next.vec       = `VEC_RESERVED;
            s_next.st        = ST_PUSH;
          end else begin
            s_next = trap(s_reg, `VEC_RESERVED);
          end
        end else if (s_reg.insn[14:6] == 9'(`OP_DEC) || s_reg.insn[14:6] == 9'(`OP_INC)) begin
          if (s_reg.insn[6]) begin
            res = (is_byte ? {8'h00, opb} : opw) - 16'h0001;
            s_next.processor_status_word[1] = is_byte ? (opb == 8'h80) : (opw == 16'h8000);
          end else begin
            res = (is_byte ? {8'h00, opb} : opw) + 16'h0001;
            s_next.processor_status_word[1] = is_byte ? (opb == 8'h7F) : (opw == 16'h7FFF);
          end
          s_next.processor_status_word[3] = is_byte ? res[7] : res[15];
          s_next.processor_status_word[2] = is_byte ? (res[7:0] == 8'h00) : (res == 16'h0000);
          if (mode0) begin
            s_next = wr_reg(s_next, s_reg.insn[2:0], is_byte ? {opw[15:8], res[7:0]} : res);
          end else begin
            mw = '{we: 1'b1, addr: s_reg.ea, data: is_byte ? {res[7:0], res[7:0]} : res,
                   be: is_byte ? (s_reg.ea[0] ? 2'b10 : 2'b01) : 2'b11};
          end
        end else if (s_reg.insn[15:9] == `OP7_DIVIDE) begin
          quo = dvd / dvs;
          rem = dvd % dvs;
          if (opw == 16'h0000) begin
            s_next.processor_status_word[1:0] = 2'b11;
          end else if (quo[31:15] != 17'h00000 && quo[31:15] != 17'h1FFFF) begin
            s_next.processor_status_word[1:0] = 2'b10;
          end else begin
            s_next.processor_status_word[3:0] = {quo[15], quo[15:0] == 16'h0000, 2'b00};
            s_next = wr_reg(s_next, rr, quo[15:0]);
            s_next = wr_reg(s_next, rr | 3'd1, rem[15:0]);
          end
        end else if (s_reg.insn[15:8] == `OP8_EMULATOR) begin
          s_next = trap(s_reg, `VEC_EMULATOR);
        end else if (s_reg.insn == `OP_HALT) begin
          if (cur == `MODE_KERNEL || !MM_PRESENT) begin
            s_next.halted = 1'b1;
          end else begin
            s_next = trap(s_reg, `VEC_RESERVED);
          end
        end else if (s_reg.insn == `OP_IO_TRAP) begin
          s_next = trap(s_reg, `VEC_IO_TRAP);
        end else if (s_reg.insn[15:6] == `OP_JUMP) begin
          if (mode0) begin
            s_next = trap(s_reg, `VEC_ILLEGAL);
          end else begin
            s_next.pc = s_reg.ea;
          end
        end else if (s_reg.insn[15:9] == `OP7_CALL) begin
          if (mode0) begin
            s_next = trap(s_reg, `VEC_ILLEGAL);
          end else begin
            s_next.push_w[0] = rd_reg(s_reg, rr);
            s_next.push_cnt  = 2'd1;
            s_next = wr_reg(s_next, rr, s_reg.pc);
            s_next.pc = s_reg.ea;
            s_next.st = ST_PUSH;
          end
        end else if (s_reg.insn[15:6] == `OP_MARK) begin
          s_next.pc      = s_reg.gr[5];
          s_next.gr[5]   = m_mark;
          s_next.spb[cur] = mark_sp + 16'h0002;
        end else if (s_reg.insn[15:6] == `OP_MFP_DATA || s_reg.insn[15:6] == `OP_MFP_INSN) begin
          s_next.insn_space = s_reg.insn[15] &&
                              !(cur == `MODE_USER && prv == `MODE_USER);
          res = (mode0 && s_reg.insn[2:0] == 3'd6) ? s_reg.spb[prv] : opw;
          s_next.push_w[0] = res;
          s_next.push_cnt  = 2'd1;
          s_next.processor_status_word[3:1]  = {res[15], res == 16'h0000, 1'b0};
          s_next.st        = ST_PUSH;
        end else if (s_reg.insn[15:6] == `OP_MF_STATUS) begin
          s_next.processor_status_word[3:1] = {s_reg.processor_status_word[7], s_reg.processor_status_word[7:0] == 8'h00, 1'b0};
          if (mode0) begin
            s_next = wr_reg(s_next, s_reg.insn[2:0], {{8{s_reg.processor_status_word[7]}}, s_reg.processor_status_word[7:0]});
          end else begin
            mw = '{we: 1'b1, addr: s_reg.ea, data: {s_reg.processor_status_word[7:0], s_reg.processor_status_word[7:0]},
                   be: s_reg.ea[0] ? 2'b10 : 2'b01};
          end
        end else if (s_reg.insn == `OP_MODEL && MODEL_IMPL) begin
          s_next.gr[0] = {MODEL_SUB, MODEL_CODE};
        end else begin
          s_next = trap(s_reg, `VEC_RESERVED);
        end
      end
      ST_PUSH: begin
        s_next.spb[cur] = s_reg.spb[cur] - 16'h0002;
        mw = '{we: 1'b1, addr: s_reg.spb[cur] - 16'h0002, data: s_reg.push_w[0], be: 2'b11};
        s_next.push_w   = {16'h0000, s_reg.push_w[2], s_reg.push_w[1]};
        s_next.push_cnt = s_reg.push_cnt - 2'd1;
        if (s_reg.push_cnt == 2'd1) begin
          s_next.st = (s_reg.vec_psw || s_reg.insn[15:6] == `OP_CALL_SUP) ? ST_VEC : ST_IDLE;
        end
      end
      ST_VEC: begin
        s_next.pc = m_vec;
        if (s_reg.vec_psw) begin
          s_next.processor_status_word = m_vec2;
        end
        s_next.vec_psw = 1'b0;
        s_next.st      = ST_IDLE;
      end
      default: s_next.st = ST_IDLE;
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg     <= '0;
      s_reg.st  <= ST_IDLE;
      s_reg.processor_status_word <= `RST_PSW;
    end else begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge pclk) begin
    if (mw.we) begin
      if (mw.be[0]) begin
        mem[mw.addr[MEM_AW-1:1]][7:0] <= mw.data[7:0];
      end
      if (mw.be[1]) begin
        mem[mw.addr[MEM_AW-1:1]][15:8] <= mw.data[15:8];
      end
    end
  end

endmodule

// file: test/insn_exec_unit_checker.sv
// port assertions of the instruction execution unit
`timescale 1ns/1ps
module insn_exec_unit_checker (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // status
  input wire logic        busy,
  input wire logic        halted
);
  // ****
  // started op and busy span
  // ****
  logic [15:0] op_reg;
  logic [3:0]  cnt_reg;
  logic        go;
  assign go = psel && penable && pready && pwrite && !pslverr && paddr == 8'h00 && !busy;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_reg  <= 16'h0000;
      cnt_reg <= 4'h0;
    end else if (go) begin
      op_reg  <= pwdata[15:0];
      cnt_reg <= 4'h0;
    end else if (busy && cnt_reg != 4'hf) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ****
  // assertions
  // ****
  a_io_trap_span: assert property ($fell(busy) && op_reg == 16'h0004 |-> cnt_reg == 4'h4)
    else $error("io trap span wrong");
  a_emu_trap_span: assert property ($fell(busy) && op_reg[15:8] == 8'h88 |-> cnt_reg == 4'h4)
    else $error("emulator trap span wrong");
  a_jump_reg_trap: assert property ($fell(busy) && op_reg[15:3] == 13'h0008 |-> cnt_reg == 4'h4)
    else $error("jump register trap span wrong");
  a_call_reg_trap: assert property ($fell(busy) && op_reg[15:9] == 7'h04 && op_reg[5:3] == 3'h0
    |-> cnt_reg == 4'h4) else $error("call register trap span wrong");
  a_call_two_cycles: assert property ($fell(busy) && op_reg[15:9] == 7'h04 && op_reg[5:3] != 3'h0
    |-> cnt_reg == 4'h2) else $error("call span wrong");
  a_incdec_one_cycle: assert property ($fell(busy) && op_reg[14:7] == 8'h15 |-> cnt_reg == 4'h1)
    else $error("inc dec span wrong");
  a_super_call_span: assert property ($fell(busy) && op_reg[15:6] == 10'h038
    |-> cnt_reg inside {4'h4, 4'h5}) else $error("supervisor call span wrong");
  a_halt_sets_flag: assert property ($rose(halted) |-> op_reg == 16'h0000)
    else $error("halted without halt");
  a_start_clears_halt: assert property (go && pwdata[15:0] != 16'h0000 |=> !halted)
    else $error("halted not cleared");
  a_reply_one_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("apb wait wrong");
  c_trap_taken: cover property ($fell(busy) && cnt_reg == 4'h4);
  c_halt_entered: cover property ($rose(halted));
  c_bus_error: cover property (pready && pslverr);
endmodule

bind insn_exec_unit insn_exec_unit_checker insn_exec_unit_checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .busy(busy), .halted(halted));

// file: test/minicomputer_insn_exec_subset_test.sv
// self-checking bench of the instruction execution unit
`timescale 1ns/1ps
module minicomputer_insn_exec_subset_test;
  // ****
  // signals and design
  // ****
  localparam logic [7:0]  MC = 8'h5a; // arbitrary value
  localparam logic [7:0]  MS = 8'h3c; // arbitrary value
  localparam logic [15:0] CW [4] = '{16'h7fff, 16'h8000, 16'h127f, 16'h3480};
  localparam logic [15:0] OPS [4] = '{16'h0a81, 16'h0ac1, 16'h8a81, 16'h8ac1};
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        busy;
  logic        halted;
  int          n_errors;
  int          check_count;
  logic [31:0] seed;
  logic [31:0] rd;
  logic [31:0] r;
  logic [31:0] dd;
  logic        er;
  logic [15:0] v;
  logic [19:0] e;
  logic [35:0] x;
  logic [7:0]  b;
  insn_exec_unit #(.MODEL_CODE(MC), .MODEL_SUB(MS)) insn_exec_unit_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .busy(busy), .halted(halted));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    print_verdict();
  end
  // ****
  // helpers
  // ****
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [19:0] incdec(input int kind, input logic [15:0] a, input logic c);
    logic [15:0] s;
    logic        o;
    s = kind[0] ? a - 16'h0001 : a + 16'h0001;
    if (kind[1]) s = {a[15:8], s[7:0]};
    o = kind[1] ? a[7:0] == (kind[0] ? 8'h80 : 8'h7f) : a == (kind[0] ? 16'h8000 : 16'h7fff);
    if (kind[1]) return {s[7], s[7:0] == 8'h00, o, c, s};
    return {s[15], s == 16'h0000, o, c, s};
  endfunction
  function automatic logic [35:0] divx(input logic [31:0] n, input logic [15:0] d, input logic [3:0] cc);
    longint q;
    longint m;
    if (d == 16'h0000) return {cc[3:2], 2'b11, n};
    q = $signed(n) / $signed(d);
    m = $signed(n) % $signed(d);
    if (q > 32767 || q < -32768) return {cc[3:2], 2'b10, n};
    return {q[15], q[15:0] == 16'h0000, 2'b00, q[15:0], m[15:0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0000, d});
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rd, ex);
  endtask
  task automatic mw(input logic [15:0] a, input logic [15:0] d);
    wr(8'h14, a);
    wr(8'h18, d);
  endtask
  task automatic mr(input string nm, input logic [15:0] a, input logic [15:0] ex);
    wr(8'h14, a);
    rdc(nm, 8'h18, {16'h0000, ex});
  endtask
  task automatic run(input logic [15:0] op);
    int t;
    t = 0;
    wr(8'h00, op);
    rd = 32'h0000_0001;
    while (rd[0] !== 1'b0 && t < 20) begin
      t++;
      apb(1'b0, 8'h10, 32'h0000_0000);
    end
    if (t == 20) n_errors++;
  endtask
  task automatic trp(input logic [15:0] op, pc, ps, vec, input logic stk);
    mw(vec, vec + 16'h0300);
    mw(vec + 16'h0002, 16'h000b);
    wr(8'h1c, pc);
    wr(8'h08, ps);
    wr(8'h38, 16'h0100);
    run(op);
    rdc("trap pc", 8'h1c, {16'h0000, vec + 16'h0300});
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("trap vector", {16'h0000, rd[31:16]}, {16'h0000, vec});
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk("trap flags", {28'h0, rd[3:0]}, 32'h0000_000b);
    if (stk) begin
      rdc("trap sp", 8'h38, 32'h0000_00fc);
      mr("pushed status", 16'h00fe, ps);
      mr("pushed pc", 16'h00fc, pc);
    end
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    seed = 32'h2b25_ed91;
    n_errors = 0;
    check_count = 0;
    presetn <= 1'b0;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    paddr   <= 8'h00;
    pwdata  <= 32'h0000_0000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("psw reset", 8'h08, 32'h0000_0000);
    apb(1'b0, 8'hfc, 32'h0000_0000);
    chk("unmapped error", {31'h0, er}, 32'h0000_0001);
    for (int k = 0; k < 24; k++) begin
      r = rnd();
      v = k < 4 ? CW[k] : k < 8 ? (k[0] ? 16'h0001 : 16'hffff) : r[31:16];
      wr(8'h08, {12'h000, r[3:0]});
      wr(8'h24, v);
      run(OPS[k % 4]);
      e = incdec(k % 4, v, r[0]);
      rdc("incdec result", 8'h24, {16'h0000, e[15:0]});
      rdc("incdec flags", 8'h08, {28'h0, e[19:16]});
    end
    for (int k = 0; k < 16; k++) begin
      r = rnd();
      dd = k == 1 ? 32'hffff_fff9 : {{8{r[23]}}, r[23:0]};
      v = k == 0 ? 16'h0000 : k == 1 ? 16'h0002 : {r[31:24], r[7:0]};
      wr(8'h08, {12'h000, r[11:8]});
      wr(8'h20, dd[31:16]);
      wr(8'h24, dd[15:0]);
      wr(8'h28, v);
      run(16'h7202);
      x = divx(dd, v, r[11:8]);
      rdc("quotient", 8'h20, {16'h0000, x[31:16]});
      rdc("remainder", 8'h24, {16'h0000, x[15:0]});
      rdc("divide flags", 8'h08, {28'h0, x[35:32]});
    end
    trp(16'h0004, 16'h0040, 16'h0000, 16'h0010, 1'b1);
    for (int j = 0; j < 3; j++) begin
      r = rnd();
      b = j == 0 ? 8'h00 : j == 1 ? 8'hff : r[7:0];
      trp({8'h88, b}, 16'h0040, {12'h000, r[11:8]}, 16'h0018, 1'b1);
    end
    trp(16'h0042, 16'h0040, 16'h0000, 16'h0004, 1'b1);
    trp(16'h0943, 16'h0040, 16'h0000, 16'h0004, 1'b1);
    trp(16'h0007, 16'h0041, 16'h0000, 16'h0004, 1'b0);
    trp(16'h0000, 16'h0040, 16'hc000, 16'h0008, 1'b0);
    trp(16'h0e0b, 16'h0040, 16'h0000, 16'h0008, 1'b1);
    trp(16'h0008, 16'h0040, 16'h0000, 16'h0008, 1'b1);
    wr(8'h08, 16'h0000);
    wr(8'h34, 16'h1234);
    wr(8'h04, 16'h0300);
    wr(8'h1c, 16'h0060);
    wr(8'h38, 16'h0100);
    run(16'h094b);
    rdc("call pc", 8'h1c, 32'h0000_0300);
    rdc("call link", 8'h34, 32'h0000_0060);
    rdc("call sp", 8'h38, 32'h0000_00fe);
    mr("call push", 16'h00fe, 16'h1234);
    wr(8'h04, 16'h1234);
    run(16'h004b);
    rdc("jump pc", 8'h1c, 32'h0000_1234);
    mw(16'h0086, 16'h5555);
    wr(8'h34, 16'h0222);
    wr(8'h1c, 16'h0080);
    run(16'h0d03);
    rdc("mark sp", 8'h38, 32'h0000_0088);
    rdc("mark pc", 8'h1c, 32'h0000_0222);
    rdc("mark link", 8'h34, 32'h0000_5555);
    run(16'h0007);
    rdc("model code", 8'h20, {16'h0000, MS, MC});
    for (int j = 0; j < 3; j++) begin
      r = rnd();
      b = j == 0 ? 8'h80 : j == 1 ? 8'h00 : r[7:0] & 8'hef;
      wr(8'h08, {8'h00, b});
      run(16'h8dc2);
      rdc("status byte", 8'h28, {16'h0000, {8{b[7]}}, b});
      rdc("status flags", 8'h08, {24'h0, b[7:4], b[7], b == 8'h00, 1'b0, b[0]});
    end
    wr(8'h0c, 16'h0008);
    wr(8'h44, 16'h0120);
    wr(8'h04, 16'h0050);
    mw(16'h0050, 16'hbeef);
    mw(16'h0008, 16'h0400);
    wr(8'h1c, 16'h0044);
    wr(8'h08, 16'hc01f);
    run(16'h0e0b);
    rdc("super sp", 8'h3c, 32'h0000_011a);
    rdc("super pc", 8'h1c, 32'h0000_0400);
    rdc("super psw", 8'h08, 32'h0000_700f);
    mr("super status", 16'h011e, 16'hc010);
    mr("super pc word", 16'h011c, 16'h0044);
    mr("super operand", 16'h011a, 16'hbeef);
    wr(8'h08, 16'hf000);
    run(16'h8d4b);
    rdc("mfp sp", 8'h44, 32'h0000_011e);
    rdc("mfp flags", 8'h08, 32'h0000_f008);
    mr("mfp push", 16'h011e, 16'hbeef);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("mfp user space", {31'h0, rd[2]}, 32'h0000_0000);
    wr(8'h08, 16'h3000);
    run(16'h8d4b);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("mfp insn space", {31'h0, rd[2]}, 32'h0000_0001);
    wr(8'h08, 16'h0000);
    run(16'h0000);
    chk("halted", {31'h0, halted}, 32'h0000_0001);
    run(16'h0007);
    chk("halt cleared", {31'h0, halted}, 32'h0000_0000);
    print_verdict();
  end
endmodule
